//--- hw/bdm_consts.svh
// constants of the bridge driver serial command map
`ifndef BDM_CONSTS_SVH
`define BDM_CONSTS_SVH

// ************************************************************
// frame layout
// ************************************************************
`define BDM_FRAME_BITS 5'h10
`define BDM_CNT_MAX 5'h1f
`define BDM_ID_DONE 5'h02
`define BDM_CMD_DONE 5'h08
`define BDM_CHIP_ID 2'h0
`define BDM_VERIFY 5'h15
`define BDM_BAD_CMD_BYTE 8'hff

// ************************************************************
// setup register fields and reset values
// ************************************************************
`define BDM_SF_BIT 7
`define BDM_CHP_BIT 6
`define BDM_EN2_BIT 5
`define BDM_EN1_BIT 4
`define BDM_OC_HI 3
`define BDM_OC_LO 2
`define BDM_SETUP_RESET 6'h0e
`define BDM_FLAG_OK 1'h1
`define BDM_DIAG_NORMAL 2'h3
`define BDM_DIAG_RESET 2'h0

`endif

//--- hw/bdm_pkg.sv
// types of the bridge driver serial command map
package bdm_pkg;

  // ************************************************************
  // command codes, bits 13:8 of an input frame
  // ************************************************************
  typedef enum logic [5:0] {
    BDM_READ_IDENTITY_CMD = 6'h00,
    BDM_READ_REVISION_CMD = 6'h03,
    BDM_READ_DIAG_CMD = 6'h09,
    BDM_READ_SETUP_CMD = 6'h28,
    BDM_WRITE_SETUP_CMD = 6'h33
  } bdm_cmd_t;

endpackage

//--- hw/bdm_link_if.sv
// signals between the serial link logic and the register core
`timescale 1ns/10ps
interface bdm_link_if;
  logic [4:0] bit_cnt;
  logic [15:0] rx_word;
  logic tf;
  logic [7:0] diag_byte;
  logic [7:0] setup_byte;
  logic [7:0] id_byte;
  logic [7:0] rev_byte;

  modport link (output bit_cnt, output rx_word, input tf,
                input diag_byte, input setup_byte, input id_byte,
                input rev_byte);
  modport core (input bit_cnt, input rx_word, output tf,
                output diag_byte, output setup_byte, output id_byte,
                output rev_byte);
endinterface

//--- hw/bdm_spi_link.sv
// serial clock domain: frame shifter and in-frame response
`timescale 1ns/10ps
`include "bdm_consts.svh"
module bdm_spi_link import bdm_pkg::*; (
  input wire logic sclk_in,
  input wire logic frame_select_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  bdm_link_if.link lnk
);

  // ************************************************************
  // response byte decode
  // ************************************************************
  function automatic logic [7:0] resp_byte(input logic [5:0] cmd,
                                           input logic [7:0] diag,
                                           input logic [7:0] setup,
                                           input logic [7:0] idb,
                                           input logic [7:0] rev);
    case (cmd)
      BDM_WRITE_SETUP_CMD: resp_byte = diag; // [RQ4] [RQ5]
      BDM_READ_DIAG_CMD: resp_byte = diag; // [RQ4] [RQ6]
      BDM_READ_SETUP_CMD: resp_byte = setup; // [RQ9]
      BDM_READ_IDENTITY_CMD: resp_byte = idb; // [RQ10]
      BDM_READ_REVISION_CMD: resp_byte = rev; // [RQ10]
      default: resp_byte = `BDM_BAD_CMD_BYTE; // [RQ12]
    endcase
  endfunction

  logic fresh;
  logic [4:0] cnt;
  logic [15:0] shreg;
  logic [4:0] next_cnt;
  logic [15:0] next_shreg;
  logic [5:0] hdr;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic next_so;
  logic next_so_oe;

  // ************************************************************
  // receive side, falling edges
  // ************************************************************
  // marks a new frame while select is high; cleared by first sample
  always_ff @(negedge sclk_in or posedge frame_select_n_in) begin
    if (frame_select_n_in) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // count and shift, msb first; count saturates on long frames
  always_comb begin
    if (fresh) begin
      next_cnt = 5'h01;
      next_shreg = {15'h0000, si_in};
    end else begin
      next_cnt = (cnt == `BDM_CNT_MAX) ? cnt : cnt + 5'h01;
      next_shreg = {shreg[14:0], si_in};
    end
  end

  // input bits taken on falling edges
  always_ff @(negedge sclk_in) begin
    cnt <= next_cnt; // [RQ14] [RQ1]
    shreg <= next_shreg; // [RQ14]
  end

  assign lnk.bit_cnt = cnt;
  assign lnk.rx_word = shreg;

  // ************************************************************
  // transmit side, rising edges
  // ************************************************************
  assign hdr = {`BDM_VERIFY, lnk.tf};

  // choose the next output bit from the bits counted so far
  always_comb begin
    next_so = so_out;
    next_so_oe = so_oe_out;
    next_tx_byte = tx_byte;
    if (!fresh) begin
      if (cnt == `BDM_ID_DONE) begin
        next_so_oe = (shreg[1:0] == `BDM_CHIP_ID); // [RQ11] [RQ2]
        next_so = hdr[5]; // [RQ2]
      end else if (cnt > `BDM_ID_DONE && cnt < `BDM_CMD_DONE) begin
        next_so = hdr[3'(7 - cnt)]; // [RQ2]
      end else if (cnt == `BDM_CMD_DONE) begin
        next_tx_byte = resp_byte(shreg[5:0], lnk.diag_byte,
                                 lnk.setup_byte, lnk.id_byte,
                                 lnk.rev_byte);
        next_so = next_tx_byte[7];
        next_tx_byte = {next_tx_byte[6:0], 1'b0};
      end else if (cnt < `BDM_FRAME_BITS) begin
        next_so = tx_byte[7];
        next_tx_byte = {tx_byte[6:0], 1'b0};
      end else begin
        next_so_oe = 1'b0; // past sixteen bits the line is released
      end
    end
  end

  // output changes on rising edges; released while select is high
  always_ff @(posedge sclk_in or posedge frame_select_n_in) begin
    if (frame_select_n_in) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0; // [RQ11]
      tx_byte <= 8'h00;
    end else begin
      so_out <= next_so; // [RQ14]
      so_oe_out <= next_so_oe;
      tx_byte <= next_tx_byte;
    end
  end

endmodule

//--- hw/bdm_cmd_map.sv
// register core of the bridge driver serial command map
`timescale 1ns/10ps
`include "bdm_consts.svh"

// Behaviour
// [RQ1] frame is chip select 15:14, command 13:8, data 7:0
// [RQ2] reply: bits 15:14 released, 1,0,1,0,1, error flag, eight bits
// [RQ3] write setup code 33h; data gives modes, enables, limit select
// [RQ4] diag reply: enabled, temp, reduction, limit hit, two codes
// [RQ5] write setup returns diagnostics and leaves them latched
// [RQ6] read diagnostics returns them then clears the latched data
// [RQ7] new setup taken only while the enable pin is low
// [RQ8] setup applied only for a fully valid frame
// [RQ9] read setup returns modes, enable, lockout, limit, thresholds
// [RQ10] identity and revision reads return fixed bytes
// [RQ11] chip select not 00 keeps output released, frame ignored
// [RQ12] unknown command replies pattern, flag and eight ones
// [RQ13] error flag on bad length or command, cleared by valid frame
// [RQ14] sample on falling clock, drive on rising, commit at select rise
// [RQ15] diagnostic clear at select rise and only for valid frame
// [RQ16] master sends sixteen clocks per frame, msb first
// [RQ17] reserved setup bits 1:0 ignored on write
module bdm_cmd_map import bdm_pkg::*; #(
  parameter logic [7:0] IDENTITY = 8'h5c, // arbitrary value
  parameter logic [3:0] REV_A = 4'h2, // arbitrary value
  parameter logic [3:0] REV_B = 4'h7 // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic frame_select_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic enable_pin_in,
  input wire logic outputs_enabled_in,
  input wire logic lockout_in,
  input wire logic [1:0] threshold_in,
  input wire logic over_temperature_in,
  input wire logic limit_reduction_in,
  input wire logic current_limit_hit_in,
  input wire logic [1:0] out_one_diag_in,
  input wire logic [1:0] out_two_diag_in,
  output logic status_flag_mode_out,
  output logic pump_power_mode_out,
  output logic output_two_enable_out,
  output logic output_one_enable_out,
  output logic [1:0] current_limit_sel_out,
  output logic frame_error_flag_out
);

  bdm_link_if lnk ();

  // ************************************************************
  // serial link
  // ************************************************************
  // no reset here: select high releases the link at any time
  bdm_spi_link u_link (
    .sclk_in(sclk_in),
    .frame_select_n_in(frame_select_n_in),
    .si_in(si_in),
    .so_out(so_out),
    .so_oe_out(so_oe_out),
    .lnk(lnk)
  );

  // ************************************************************
  // decode and latch helpers
  // ************************************************************
  // commands that the map answers; any other code is a framing error
  // that sets the error flag but writes no setup and clears no diagnostics
  function automatic logic cmd_known(input logic [5:0] code);
    case (code)
      BDM_WRITE_SETUP_CMD,
      BDM_READ_DIAG_CMD,
      BDM_READ_SETUP_CMD,
      BDM_READ_IDENTITY_CMD,
      BDM_READ_REVISION_CMD: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction

  // one fault flag, low while latched; a fault in the clear cycle wins
  function automatic logic flag_next(input logic fault,
                                     input logic clr,
                                     input logic cur);
    if (fault) begin
      flag_next = 1'b0;
    end else if (clr) begin
      flag_next = `BDM_FLAG_OK;
    end else begin
      flag_next = cur;
    end
  endfunction

  // one output code; a code other than normal latches, newest first
  function automatic logic [1:0] code_next(input logic [1:0] code,
                                           input logic clr,
                                           input logic [1:0] cur);
    if (code != `BDM_DIAG_NORMAL) begin
      code_next = code;
    end else if (clr) begin
      code_next = `BDM_DIAG_NORMAL;
    end else begin
      code_next = cur;
    end
  endfunction

  // setup readback byte: modes, live enable, lockout, limit, thresholds
  function automatic logic [7:0] setup_reply(input logic [5:0] s,
                                             input logic en,
                                             input logic lock,
                                             input logic [1:0] th);
    setup_reply = {s[`BDM_SF_BIT - 2], s[`BDM_CHP_BIT - 2], en, lock,
                   s[`BDM_OC_HI - 2], s[`BDM_OC_LO - 2], th}; // [RQ9]
  endfunction

  // diagnostic reply byte, shared by write setup and read diagnostics
  function automatic logic [7:0] diag_reply(input logic en,
                                            input logic [2:0] flags,
                                            input logic [1:0] two,
                                            input logic [1:0] one);
    diag_reply = {en, flags, two, one}; // [RQ4]
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic sel_meta;
  logic sel_sync;
  logic sel_prev;
  logic en_meta;
  logic en_sync;
  logic next_sel_meta;
  logic next_sel_sync;
  logic next_sel_prev;
  logic next_en_meta;
  logic next_en_sync;

  // two stages for select and enable; select edge seen on the second
  // a third flop keeps the old select level to find its rising edge
  always_comb begin
    next_sel_meta = frame_select_n_in;
    next_sel_sync = sel_meta;
    next_sel_prev = sel_sync;
    next_en_meta = enable_pin_in;
    next_en_sync = en_meta;
  end

  // reset parks select high so that release makes no false frame end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
      sel_prev <= 1'b1;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      sel_meta <= next_sel_meta;
      sel_sync <= next_sel_sync;
      sel_prev <= next_sel_prev;
      en_meta <= next_en_meta;
      en_sync <= next_en_sync;
    end
  end

  // ************************************************************
  // frame check at the rising select edge
  // ************************************************************
  logic frame_end;
  logic id_ok;
  logic cmd_ok;
  logic len_ok;
  logic frame_valid;
  logic [5:0] cmd;

  // count and word are idle once select is high, so read them here
  // they cross unsynchronised but stay still for several clocks here
  assign frame_end = sel_sync & ~sel_prev; // [RQ14]
  assign cmd = lnk.rx_word[13:8]; // [RQ1]
  assign id_ok = (lnk.rx_word[15:14] == `BDM_CHIP_ID); // [RQ11]
  assign len_ok = (lnk.bit_cnt == `BDM_FRAME_BITS); // [RQ16]

  assign cmd_ok = cmd_known(cmd); // [RQ12] [RQ13]

  // a write or a clear needs chip select, length and command all right
  assign frame_valid = frame_end & id_ok & len_ok & cmd_ok; // [RQ8]

  // ************************************************************
  // setup register, error flag and diagnostics
  // ************************************************************
  logic [5:0] setup;
  logic tf;
  logic ot;
  logic limit_reduction_flag;
  logic current_limit_hit_flag;
  logic [1:0] d_one;
  logic [1:0] d_two;
  logic diag_clr;
  logic [5:0] next_setup;
  logic next_tf;
  logic next_ot;
  logic next_limit_reduction_flag;
  logic next_current_limit_hit_flag;
  logic [1:0] next_d_one;
  logic [1:0] next_d_two;

  // only a fully valid read diagnostics frame clears the latches
  assign diag_clr = frame_valid && cmd == BDM_READ_DIAG_CMD; // [RQ15]

  // a fault present in the clear cycle stays latched
  always_comb begin
    next_setup = setup;
    if (frame_valid && cmd == BDM_WRITE_SETUP_CMD && !en_sync) begin
      next_setup = lnk.rx_word[7:2]; // [RQ3] [RQ7] [RQ17]
    end
    // a frame for another chip leaves the error flag as it was
    next_tf = tf;
    if (frame_end && id_ok) begin
      next_tf = !(len_ok && cmd_ok); // [RQ13]
    end
    next_ot = flag_next(over_temperature_in, diag_clr, ot); // [RQ6] [RQ5]
    next_limit_reduction_flag = flag_next(limit_reduction_in, diag_clr, limit_reduction_flag); // [RQ6]
    next_current_limit_hit_flag = flag_next(current_limit_hit_in, diag_clr, current_limit_hit_flag); // [RQ6]
    next_d_one = code_next(out_one_diag_in, diag_clr, d_one); // [RQ6]
    next_d_two = code_next(out_two_diag_in, diag_clr, d_two); // [RQ6]
  end

  // core registers, reset to the power-up defaults
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      setup <= `BDM_SETUP_RESET;
      tf <= 1'b0;
      ot <= `BDM_FLAG_OK;
      limit_reduction_flag <= `BDM_FLAG_OK;
      current_limit_hit_flag <= `BDM_FLAG_OK;
      d_one <= `BDM_DIAG_RESET;
      d_two <= `BDM_DIAG_RESET;
    end else begin
      setup <= next_setup;
      tf <= next_tf;
      ot <= next_ot;
      limit_reduction_flag <= next_limit_reduction_flag;
      current_limit_hit_flag <= next_current_limit_hit_flag;
      d_one <= next_d_one;
      d_two <= next_d_two;
    end
  end

  // ************************************************************
  // reply snapshot, frozen while a frame is in progress
  // ************************************************************
  logic [7:0] diag_snap;
  logic [7:0] setup_snap;
  logic tf_snap;
  logic [7:0] next_diag_snap;
  logic [7:0] next_setup_snap;
  logic next_tf_snap;

  // the link reads these only while select is low, when they hold still
  always_comb begin
    next_diag_snap = diag_snap;
    next_setup_snap = setup_snap;
    next_tf_snap = tf_snap;
    if (sel_sync) begin
      next_diag_snap = diag_reply(outputs_enabled_in, {ot, limit_reduction_flag, current_limit_hit_flag},
                                  d_two, d_one); // [RQ4]
      next_setup_snap = setup_reply(setup, outputs_enabled_in, lockout_in,
                                    threshold_in); // [RQ9]
      next_tf_snap = tf; // [RQ13]
    end
  end

  // snapshot cleared under reset, refilled on the first idle clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      diag_snap <= 8'h00;
      setup_snap <= 8'h00;
      tf_snap <= 1'b0;
    end else begin
      diag_snap <= next_diag_snap;
      setup_snap <= next_setup_snap;
      tf_snap <= next_tf_snap;
    end
  end

  assign lnk.diag_byte = diag_snap;
  assign lnk.setup_byte = setup_snap;
  assign lnk.tf = tf_snap;
  // identity and revision are fixed when the block is built
  assign lnk.id_byte = IDENTITY; // [RQ10]
  assign lnk.rev_byte = {REV_A, REV_B}; // [RQ10]

  // ************************************************************
  // outputs, all from registers
  // ************************************************************
  // the setup fields drive their pins straight from the register
  assign status_flag_mode_out = setup[`BDM_SF_BIT - 2];
  assign pump_power_mode_out = setup[`BDM_CHP_BIT - 2];
  assign output_two_enable_out = setup[`BDM_EN2_BIT - 2];
  assign output_one_enable_out = setup[`BDM_EN1_BIT - 2];
  assign current_limit_sel_out = setup[`BDM_OC_HI - 2:`BDM_OC_LO - 2];
  assign frame_error_flag_out = tf;

endmodule

//--- tb/bdm_cmd_map_asserts.sv
// port checker of the serial command map
`timescale 1ns/10ps
`include "bdm_consts.svh"
module bdm_map_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic frame_select_n_in,
  input wire logic si_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic enable_pin_in,
  input wire logic status_flag_mode_out,
  input wire logic pump_power_mode_out,
  input wire logic output_two_enable_out,
  input wire logic output_one_enable_out,
  input wire logic [1:0] current_limit_sel_out,
  input wire logic frame_error_flag_out
);
  // ****
  // helpers
  // ****
  logic [4:0] rcnt;
  logic [1:0] idr;
  logic [5:0] su;
  // setup fields as one word
  assign su = {status_flag_mode_out, pump_power_mode_out,
    output_two_enable_out, output_one_enable_out, current_limit_sel_out};
  // rising serial edges seen in this frame
  always_ff @(posedge sclk_in or posedge frame_select_n_in) begin
    if (frame_select_n_in) rcnt <= 5'h00;
    else if (rcnt != 5'h1f) rcnt <= rcnt + 5'h01;
  end
  // chip select field of this frame
  always_ff @(negedge sclk_in or posedge frame_select_n_in) begin
    if (frame_select_n_in) idr <= 2'h0;
    else if (rcnt < 5'h03) idr <= {idr[0], si_in};
  end
  // ****
  // system clock side
  // ****
  sel_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    frame_select_n_in && $past(frame_select_n_in) |-> !so_oe_out)
    else $error("output driven while deselected");
  setup_quiet_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    !$stable(su) |-> frame_select_n_in && $past(frame_select_n_in))
    else $error("setup changed inside a frame");
  flag_quiet_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    $changed(frame_error_flag_out) |-> $past(frame_select_n_in))
    else $error("error flag changed inside a frame");
  enable_hold_a: assert property (@(posedge clk_in)
    disable iff (rst_in)
    enable_pin_in [*4] |=> $stable(su))
    else $error("setup written while enable high");
  reset_vals_a: assert property (@(posedge clk_in)
    $fell(rst_in) |-> su == `BDM_SETUP_RESET && !frame_error_flag_out)
    else $error("wrong reset values");
  // ****
  // serial clock side
  // ****
  early_quiet_a: assert property (@(negedge sclk_in)
    disable iff (frame_select_n_in) rcnt < 5'h03 |-> !so_oe_out)
    else $error("output driven before chip select decoded");
  foreign_id_a: assert property (@(negedge sclk_in)
    disable iff (frame_select_n_in)
    rcnt >= 5'h03 && idr != 2'h0 |-> !so_oe_out)
    else $error("output driven for foreign chip select");
  own_id_a: assert property (@(negedge sclk_in)
    disable iff (frame_select_n_in)
    rcnt inside {[5'h03:5'h10]} && idr == 2'h0 |-> so_oe_out)
    else $error("output not driven for own chip select");
  verify_pattern_a: assert property (@(negedge sclk_in)
    disable iff (frame_select_n_in)
    rcnt inside {[5'h03:5'h07]} && idr == 2'h0 |-> so_out == rcnt[0])
    else $error("wrong verification pattern");
  flag_bit_a: assert property (@(negedge sclk_in)
    disable iff (frame_select_n_in)
    rcnt == 5'h08 && idr == 2'h0 |-> so_out == frame_error_flag_out)
    else $error("wrong error flag bit in reply");
  // main scenarios reached
  cover property (@(posedge clk_in) $rose(frame_error_flag_out));
  cover property (@(posedge clk_in) !$stable(su));
  cover property (@(negedge sclk_in) rcnt == 5'h03 && idr != 2'h0);
endmodule
bind bdm_cmd_map bdm_map_chk chk_u (.clk_in, .rst_in, .sclk_in,
  .frame_select_n_in, .si_in, .so_out, .so_oe_out, .enable_pin_in,
  .status_flag_mode_out, .pump_power_mode_out, .output_two_enable_out,
  .output_one_enable_out, .current_limit_sel_out, .frame_error_flag_out);

//--- tb/bdm_spi_master.sv
// serial master model that frames commands to the device
`timescale 1ns/10ps
module bdm_spi_master (
  output logic sclk_out,
  output logic sel_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  logic [15:0] rx;
  logic [15:0] rx_oe;
  // ****
  // frame engine
  // ****
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b0;
    mosi_out = 1'b0;
    #1;
    sel_n_out = 1'b1; // clean rising select parks the link at start
  end
  // n clocks msb first, clock still between frames
  task automatic xfer(input logic [15:0] w, input int n);
    sel_n_out = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      mosi_out = w[15 - i];
      sclk_out = 1'b1;
      #32;
      // a released line floats, so no stale bit can pass as data
      rx = {rx[14:0], miso_oe_in ? miso_in : 1'bz};
      rx_oe = {rx_oe[14:0], miso_oe_in};
      sclk_out = 1'b0;
      #32;
    end
    #40;
    sel_n_out = 1'b1;
    mosi_out = ~mosi_out; // data line shows no stale bit
    #400;
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench of the serial command map
`timescale 1ns/10ps
`include "bdm_consts.svh"
`define BDM_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  fails++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb import bdm_pkg::*;;
  localparam logic [7:0] ID_V = 8'h3a; // arbitrary value
  localparam logic [3:0] RA = 4'h4; // arbitrary value
  localparam logic [3:0] RB = 4'h9; // arbitrary value
  int fails;
  int n_checks;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_pin = 1'b0;
  logic ot = 1'b0;
  logic limit_reduction_flag = 1'b0;
  logic current_limit_hit_flag = 1'b0;
  logic [1:0] d1 = 2'h3;
  logic [1:0] d2 = 2'h3;
  logic out_en = 1'b1;
  logic lock = 1'b1;
  logic [1:0] thr = 2'h2;
  logic sclk, sel_n, mosi, so, so_oe, err_flag;
  logic [5:0] su;
  // ****
  // device and master
  // ****
  always #25 clk = ~clk;
  bdm_cmd_map #(.IDENTITY(ID_V), .REV_A(RA), .REV_B(RB)) dut_u (
    .clk_in(clk), .rst_in(rst), .sclk_in(sclk), .frame_select_n_in(sel_n),
    .si_in(mosi), .so_out(so), .so_oe_out(so_oe), .enable_pin_in(en_pin),
    .outputs_enabled_in(out_en), .lockout_in(lock), .threshold_in(thr),
    .over_temperature_in(ot), .limit_reduction_in(limit_reduction_flag),
    .current_limit_hit_in(current_limit_hit_flag), .out_one_diag_in(d1),
    .out_two_diag_in(d2), .status_flag_mode_out(su[5]),
    .pump_power_mode_out(su[4]), .output_two_enable_out(su[3]),
    .output_one_enable_out(su[2]), .current_limit_sel_out(su[1:0]),
    .frame_error_flag_out(err_flag));
  bdm_spi_master mst_u (.sclk_out(sclk), .sel_n_out(sel_n),
    .mosi_out(mosi), .miso_in(so), .miso_oe_in(so_oe));
  // ****
  // shared tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // full frame with its reply judged
  task automatic frame(input logic [15:0] w, input logic tf,
    input logic [7:0] b);
    mst_u.xfer(w, 16);
    `BDM_CHK("reply", {`BDM_VERIFY, tf, b}, mst_u.rx[13:0])
    `BDM_CHK("reply enable", 16'h3fff, mst_u.rx_oe)
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_ids;
    `BDM_CHK("setup", `BDM_SETUP_RESET, su)
    `BDM_CHK("error flag", 1'b0, err_flag)
    frame({2'h0, BDM_READ_IDENTITY_CMD, 8'h00}, 1'b0, ID_V);
    frame({2'h0, BDM_READ_REVISION_CMD, 8'h55}, 1'b0, {RA, RB});
  endtask
  task automatic t_diag;
    frame({2'h0, BDM_READ_DIAG_CMD, 8'h00}, 1'b0, 8'hf0);
    tick(1);
    ot = 1'b1;
    current_limit_hit_flag = 1'b1;
    d1 = 2'h1;
    d2 = 2'h2;
    tick(2);
    ot = 1'b0;
    current_limit_hit_flag = 1'b0;
    d1 = 2'h3;
    d2 = 2'h3;
    frame({2'h0, BDM_WRITE_SETUP_CMD, 8'hc7}, 1'b0, 8'ha9);
    `BDM_CHK("setup", 6'h31, su)
    frame({2'h0, BDM_WRITE_SETUP_CMD, 8'hc7}, 1'b0, 8'ha9);
    frame({2'h0, BDM_READ_DIAG_CMD, 8'h00}, 1'b0, 8'ha9);
    tick(1);
    limit_reduction_flag = 1'b1;
    tick(2);
    limit_reduction_flag = 1'b0;
    frame({2'h0, BDM_READ_DIAG_CMD, 8'h00}, 1'b0, 8'hdf);
    frame({2'h0, BDM_READ_SETUP_CMD, 8'h00}, 1'b0, 8'hf6);
  endtask
  task automatic t_enable;
    tick(1);
    en_pin = 1'b1;
    tick(4);
    frame({2'h0, BDM_WRITE_SETUP_CMD, 8'h3c}, 1'b0, 8'hff);
    `BDM_CHK("setup", 6'h31, su)
    tick(1);
    en_pin = 1'b0;
    out_en = 1'b0;
    lock = 1'b0;
    thr = 2'h1;
    frame({2'h0, BDM_READ_SETUP_CMD, 8'h00}, 1'b0, 8'hc5);
    frame({2'h0, BDM_READ_DIAG_CMD, 8'h00}, 1'b0, 8'h7f);
    tick(1);
    out_en = 1'b1;
    lock = 1'b1;
    thr = 2'h2;
  endtask
  task automatic t_errors;
    frame({2'h0, 6'h3f, 8'h00}, 1'b0, 8'hff);
    `BDM_CHK("error flag", 1'b1, err_flag)
    mst_u.xfer(16'h4000, 16);
    `BDM_CHK("foreign enable", 16'h0000, mst_u.rx_oe)
    `BDM_CHK("error flag", 1'b1, err_flag)
    frame({2'h0, BDM_READ_IDENTITY_CMD, 8'h00}, 1'b1, ID_V);
    `BDM_CHK("error flag", 1'b0, err_flag)
    mst_u.xfer({2'h0, BDM_WRITE_SETUP_CMD, 8'h0c}, 15);
    `BDM_CHK("error flag", 1'b1, err_flag)
    `BDM_CHK("setup", 6'h31, su)
    frame({2'h0, BDM_READ_SETUP_CMD, 8'h00}, 1'b1, 8'hf6);
  endtask
  // ****
  // run control
  // ****
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // reset for ten cycles, then every scenario in turn
  initial begin
    tick(10);
    rst = 1'b0;
    tick(3);
    t_ids;
    t_diag;
    t_enable;
    t_errors;
    give_verdict;
  end
  // about ten times the expected run of some thirty microseconds
  initial begin
    #300000;
    fails++;
    give_verdict;
  end
endmodule
